// ==== inc/relay_duty_map.vh ====
// Register addresses, mode encodings, reset values and timing constants of the threshold relay and duty output
`ifndef RELAY_DUTY_MAP_VH
`define RELAY_DUTY_MAP_VH
`define ADDR_MODE 8'h00
`define ADDR_THR1 8'h04
`define ADDR_THR2 8'h08
`define ADDR_BAND 8'h0C
`define ADDR_DELAY 8'h10
`define ADDR_RANGE_LO 8'h14
`define ADDR_RANGE_HI 8'h18
`define ADDR_PERIOD 8'h1C
`define ADDR_MINTIME 8'h20
`define ADDR_SOURCE 8'h24
`define ADDR_STATUS 8'h28
`define MODE_DISABLED 3'h0
`define MODE_ON_ABOVE 3'h1
`define MODE_OFF_ABOVE 3'h2
`define MODE_INSIDE 3'h3
`define MODE_OUTSIDE 3'h4
`define MODE_DUTY 3'h5
`define FAULT_OFF 2'h0
`define FAULT_ON 2'h1
`define FAULT_HOLD 2'h2
`define SRC_INPUT 2'h0
`define SRC_BUS 2'h1
`define SRC_LOOP_H 2'h2
`define SRC_LOOP_C 2'h3
`define TICK_FAST_NS 1000000
`define TICK_SLOW_NS 100000000
`define CLK_NS 8
`define PCT_FULL 8'h64
`define RANGE_HI_RST 16'h0064
`define PERIOD_RST 16'h000A
`endif

// ==== rtl/threshold_relay_and_duty_output.v ====
// Window comparator relay and duty-cycle open-collector output with AHB-Lite registers
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "relay_duty_map.vh"
`default_nettype none
module threshold_relay_and_duty_output #(
  parameter integer TICK_FAST_CYC = `TICK_FAST_NS / `CLK_NS,
  parameter integer TICK_SLOW_CYC = `TICK_SLOW_NS / `CLK_NS,
  parameter HAS_OC = 1'b1
) (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire signed [15:0] measValue,
  input wire signed [15:0] loopHValue,
  input wire signed [15:0] loopCValue,
  input wire alarm,
  output reg relayOut,
  output reg ocOut
);
  // Registers
  reg [2:0] mode_r;
  reg [1:0] faultSel_r;
  reg tickUnit_r;
  reg [1:0] source_r;
  reg signed [15:0] firstThreshold_r, secondThreshold_r, deadbandWidth_r;
  reg [15:0] assertDelay_r, releaseDelay_r;
  reg signed [15:0] rangeLowBound_r, rangeHighBound_r, busValue_r;
  reg [15:0] period_r, minHighTime_r, minLowTime_r;
  reg [7:0] faultFillSetting_r;
  reg wrPend_r;
  reg [7:0] wrAddr_r;

  function signed [16:0] sx;
    input signed [15:0] v;
    sx = {v[15], v};
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire addrPhase = hsel & htrans[1] & hready;

  always @(posedge mclk)
  begin
    if (rst)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hrdata <= 32'h0;
      mode_r <= `MODE_DISABLED;
      faultSel_r <= `FAULT_OFF;
      tickUnit_r <= 1'b0;
      source_r <= `SRC_INPUT;
      firstThreshold_r <= 16'h0;
      secondThreshold_r <= 16'h0;
      deadbandWidth_r <= 16'h0;
      assertDelay_r <= 16'h0;
      releaseDelay_r <= 16'h0;
      rangeLowBound_r <= 16'h0;
      rangeHighBound_r <= `RANGE_HI_RST;
      busValue_r <= 16'h0;
      period_r <= `PERIOD_RST;
      minHighTime_r <= 16'h0;
      minLowTime_r <= 16'h0;
      faultFillSetting_r <= 8'h00;
    end
    else if (ce)
    begin
      wrPend_r <= addrPhase & hwrite;
      wrAddr_r <= haddr;
      if (wrPend_r)
      begin
        if (wrAddr_r == `ADDR_MODE)
        begin
          // Duty mode is refused on a part without an open-collector output
          if (hwdata[2:0] != `MODE_DUTY || HAS_OC)
            mode_r <= hwdata[2:0];
          faultSel_r <= hwdata[5:4];
          tickUnit_r <= hwdata[8];
        end
        else if (wrAddr_r == `ADDR_THR1)
          firstThreshold_r <= hwdata[15:0];
        else if (wrAddr_r == `ADDR_THR2)
          secondThreshold_r <= hwdata[15:0];
        else if (wrAddr_r == `ADDR_BAND)
          deadbandWidth_r <= hwdata[15:0];
        else if (wrAddr_r == `ADDR_DELAY)
        begin
          assertDelay_r <= hwdata[15:0];
          releaseDelay_r <= hwdata[31:16];
        end
        else if (wrAddr_r == `ADDR_RANGE_LO)
          rangeLowBound_r <= hwdata[15:0];
        else if (wrAddr_r == `ADDR_RANGE_HI)
          rangeHighBound_r <= hwdata[15:0];
        else if (wrAddr_r == `ADDR_PERIOD)
          period_r <= hwdata[15:0];
        else if (wrAddr_r == `ADDR_MINTIME)
        begin
          minHighTime_r <= hwdata[15:0];
          minLowTime_r <= hwdata[31:16];
        end
        else if (wrAddr_r == `ADDR_SOURCE)
        begin
          source_r <= hwdata[1:0];
          faultFillSetting_r <= hwdata[15:8];
          busValue_r <= hwdata[31:16];
        end
      end
      if (addrPhase & ~hwrite)
      begin
        if (haddr == `ADDR_MODE)
          hrdata <= {23'h0, tickUnit_r, 2'h0, faultSel_r, 1'b0, mode_r};
        else if (haddr == `ADDR_THR1)
          hrdata <= {16'h0, firstThreshold_r};
        else if (haddr == `ADDR_THR2)
          hrdata <= {16'h0, secondThreshold_r};
        else if (haddr == `ADDR_BAND)
          hrdata <= {16'h0, deadbandWidth_r};
        else if (haddr == `ADDR_DELAY)
          hrdata <= {releaseDelay_r, assertDelay_r};
        else if (haddr == `ADDR_RANGE_LO)
          hrdata <= {16'h0, rangeLowBound_r};
        else if (haddr == `ADDR_RANGE_HI)
          hrdata <= {16'h0, rangeHighBound_r};
        else if (haddr == `ADDR_PERIOD)
          hrdata <= {16'h0, period_r};
        else if (haddr == `ADDR_MINTIME)
          hrdata <= {minLowTime_r, minHighTime_r};
        else if (haddr == `ADDR_SOURCE)
          hrdata <= {busValue_r, faultFillSetting_r, 6'h0, source_r};
        else if (haddr == `ADDR_STATUS)
          hrdata <= {29'h0, alarm, ocOut, relayOut};
        else
          hrdata <= 32'h0;
      end
    end
  end

  // Prescaled tick selected by time unit
  reg [31:0] preCnt_r;
  wire [31:0] preTop = tickUnit_r ? TICK_SLOW_CYC - 1 : TICK_FAST_CYC - 1;
  wire tick = (preCnt_r >= preTop);
  always @(posedge mclk)
  begin
    if (rst)
      preCnt_r <= 32'h0;
    else if (ce)
      preCnt_r <= tick ? 32'h0 : preCnt_r + 32'h1;
  end

  // Window comparator
  wire signed [16:0] thA = sx(firstThreshold_r);
  wire signed [16:0] thB = sx(secondThreshold_r);
  wire signed [16:0] thLo = (thA < thB) ? thA : thB;
  wire signed [16:0] thHi = (thA < thB) ? thB : thA;
  wire signed [16:0] db = sx(deadbandWidth_r);
  wire signed [17:0] inp = {{2{measValue[15]}}, measValue};
  wire signed [17:0] loUp = {thLo[16], thLo} + {db[16], db};
  wire signed [17:0] loDn = {thLo[16], thLo} - {db[16], db};
  wire signed [17:0] hiUp = {thHi[16], thHi} + {db[16], db};
  wire signed [17:0] hiDn = {thHi[16], thHi} - {db[16], db};
  wire signed [17:0] t1Up = {thA[16], thA} + {db[16], db};
  wire signed [17:0] t1Dn = {thA[16], thA} - {db[16], db};
  reg wantOn, wantOff;
  always @*
  begin
    wantOn = 1'b0;
    wantOff = 1'b0;
    case (mode_r)
      `MODE_ON_ABOVE:
      begin
        wantOn = inp > t1Up;
        wantOff = inp < t1Dn;
      end
      `MODE_OFF_ABOVE:
      begin
        wantOn = inp < t1Dn;
        wantOff = inp > t1Up;
      end
      `MODE_INSIDE:
      begin
        wantOn = (inp > loUp) && (inp < hiDn);
        wantOff = (inp < loDn) || (inp > hiUp);
      end
      `MODE_OUTSIDE:
      begin
        wantOn = (inp < loDn) || (inp > hiUp);
        wantOff = (inp > loUp) && (inp < hiDn);
      end
      default:
      begin
        wantOn = 1'b0;
        wantOff = 1'b0;
      end
    endcase
  end

  reg [15:0] dlyCnt_r;
  always @(posedge mclk)
  begin
    if (rst)
    begin
      relayOut <= 1'b0;
      dlyCnt_r <= 16'h0;
    end
    else if (ce)
    begin
      if (mode_r == `MODE_DISABLED || mode_r == `MODE_DUTY)
      begin
        relayOut <= 1'b0;
        dlyCnt_r <= 16'h0;
      end
      else if (alarm)
      begin
        dlyCnt_r <= 16'h0;
        if (faultSel_r == `FAULT_ON)
          relayOut <= 1'b1;
        else if (faultSel_r == `FAULT_OFF)
          relayOut <= 1'b0;
      end
      else if (~relayOut & wantOn)
      begin
        if (dlyCnt_r >= assertDelay_r)
        begin
          relayOut <= 1'b1;
          dlyCnt_r <= 16'h0;
        end
        else if (tick)
          dlyCnt_r <= dlyCnt_r + 16'h1;
      end
      else if (relayOut & wantOff)
      begin
        if (dlyCnt_r >= releaseDelay_r)
        begin
          relayOut <= 1'b0;
          dlyCnt_r <= 16'h0;
        end
        else if (tick)
          dlyCnt_r <= dlyCnt_r + 16'h1;
      end
      else
        dlyCnt_r <= 16'h0;
    end
  end

  // Duty generator
  reg signed [15:0] srcVal;
  always @*
  begin
    case (source_r)
      `SRC_INPUT: srcVal = measValue;
      `SRC_BUS: srcVal = busValue_r;
      `SRC_LOOP_H: srcVal = loopHValue;
      default: srcVal = loopCValue;
    endcase
  end
  wire signed [16:0] spanS = sx(rangeHighBound_r) - sx(rangeLowBound_r);
  wire signed [16:0] offS = sx(srcVal) - sx(rangeLowBound_r);
  wire [15:0] span = spanS[15:0];
  wire [15:0] off = offS[15:0];
  wire [31:0] linHigh = (spanS > 0) ? (period_r * off) / span : 32'h0;
  wire [23:0] alHigh = (period_r * faultFillSetting_r) / `PCT_FULL;
  reg [15:0] highCalc;
  always @*
  begin
    if (alarm)
      highCalc = (faultFillSetting_r >= `PCT_FULL) ? period_r : alHigh[15:0];
    else if (offS < 0)
      highCalc = 16'h0;
    else if (offS >= spanS)
      highCalc = period_r;
    else
      highCalc = linHigh[15:0];
    if (highCalc != 16'h0 && highCalc < minHighTime_r)
      highCalc = minHighTime_r;
    if (highCalc != period_r && period_r - highCalc < minLowTime_r)
      highCalc = period_r - minLowTime_r;
  end
  wire tooLong = ({1'b0, minHighTime_r} + {1'b0, minLowTime_r}) > {1'b0, period_r};

  reg [15:0] perCnt_r, highLat_r;
  reg blockLat_r;
  wire dutyOn = (mode_r == `MODE_DUTY) && HAS_OC;
  wire perEnd = (perCnt_r + 16'h1 >= period_r);
  always @(posedge mclk)
  begin
    if (rst)
    begin
      perCnt_r <= 16'h0;
      highLat_r <= 16'h0;
      blockLat_r <= 1'b1;
      ocOut <= 1'b0;
    end
    else if (ce)
    begin
      if (~dutyOn)
      begin
        perCnt_r <= 16'h0;
        highLat_r <= 16'h0;
        blockLat_r <= 1'b1;
        ocOut <= 1'b0;
      end
      else
      begin
        if (tick)
        begin
          if (perEnd)
          begin
            perCnt_r <= 16'h0;
            highLat_r <= highCalc;
            blockLat_r <= tooLong;
          end
          else
            perCnt_r <= perCnt_r + 16'h1;
        end
        ocOut <= ~blockLat_r && (perCnt_r < highLat_r);
      end
    end
  end
endmodule // threshold_relay_and_duty_output
`default_nettype wire

// ==== tb/oc_load_model.sv ====
// Open-collector load that measures fill and period of the duty output
`timescale 1ns/1ps
`default_nettype none
module oc_load_model (
  input wire logic mclk,
  input wire logic clear,
  input wire logic ocOut,
  output int highCnt,
  output int lastPeriod
);
  int sinceRise = 0;
  logic prevOc = 1'b0;
  always @(posedge mclk)
  begin
    prevOc <= ocOut;
    sinceRise <= sinceRise + 1;
    if (clear)
      highCnt <= 0;
    else if (ocOut === 1'b1)
      highCnt <= highCnt + 1;
    if (ocOut && !prevOc)
    begin
      lastPeriod <= sinceRise;
      sinceRise <= 1;
    end
  end
endmodule // oc_load_model
`default_nettype wire

// ==== tb/relay_duty_props.sv ====
// Checker for the bus, reset, freeze and relay-idle behaviour at the ports
`timescale 1ns/1ps
`default_nettype none
`include "relay_duty_map.vh"
module relay_duty_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic alarm,
  input wire logic relayOut,
  input wire logic ocOut
);
  wire logic taken = hsel && htrans[1] && hready && ce;
  wire logic rdTaken = taken && !hwrite;
  logic wrMode;
  logic [2:0] modeR;
  // Shadow of the mode field, so relay checks need no register read
  always @(posedge mclk)
  begin
    if (rst)
    begin
      wrMode <= 1'b0;
      modeR <= `MODE_DISABLED;
    end
    else if (ce)
    begin
      wrMode <= taken && hwrite && haddr == `ADDR_MODE;
      if (wrMode)
        modeR <= hwdata[2:0];
    end
  end
  wire logic idle = modeR == `MODE_DISABLED || modeR == `MODE_DUTY;
  wire logic dutyMode = modeR == `MODE_DUTY;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_reset_clears: assert property ($fell(rst) |-> !relayOut && !ocOut && hrdata == 32'h0)
    else $error("outputs not cleared by reset");
  a_ce_freeze: assert property (!ce |=> $stable(relayOut) && $stable(ocOut) && $stable(hrdata))
    else $error("state moved with ce low");
  a_oc_idle: assert property (!dutyMode && ce ##1 !dutyMode |-> !ocOut)
    else $error("ocOut high outside duty mode");
  a_relay_idle: assert property (idle ##1 idle |-> !relayOut)
    else $error("relay on in idle mode");
  a_status_read: assert property (rdTaken && haddr == `ADDR_STATUS |=>
    hrdata[2:0] == {$past(alarm), $past(ocOut), $past(relayOut)}) else $error("status wrong");
  a_unmapped_zero: assert property (rdTaken && haddr > `ADDR_STATUS |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_data_stands: assert property (!rdTaken |=> $stable(hrdata)) else $error("hrdata moved");
  cover property (rdTaken && haddr == `ADDR_STATUS);
  cover property ($rose(relayOut));
  cover property ($rose(ocOut));
endmodule // relay_duty_props
bind threshold_relay_and_duty_output relay_duty_props i_props (.mclk(mclk), .rst(rst), .ce(ce),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .alarm(alarm), .relayOut(relayOut),
  .ocOut(ocOut));
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench of the threshold relay and duty output
`timescale 1ns/1ps
`default_nettype none
`include "relay_duty_map.vh"
module tb_top;
  typedef struct packed {logic [7:0] c; logic [15:0] a; logic [15:0] b; logic [15:0] m;
    logic al; logic ex;} relRow;
  typedef struct packed {logic [31:0] s; logic [31:0] n; logic [15:0] m; logic al;
    logic [7:0] h;} dutyRow;
  relRow rr[15] = '{'{8'h01, 16'h64, 16'h64, 16'h6F, 1'h0, 1'h1},
    '{8'h01, 16'h64, 16'h64, 16'h59, 1'h0, 1'h0}, '{8'h01, 16'h64, 16'h64, 16'h69, 1'h0, 1'h0},
    '{8'h02, 16'h64, 16'h64, 16'h6F, 1'h0, 1'h0},
    '{8'h02, 16'h64, 16'h64, 16'h59, 1'h0, 1'h1}, '{8'h03, 16'hC8, 16'h64, 16'h96, 1'h0, 1'h1},
    '{8'h03, 16'hC8, 16'h64, 16'hFA, 1'h0, 1'h0}, '{8'h04, 16'h64, 16'hC8, 16'h96, 1'h0, 1'h0},
    '{8'h04, 16'h64, 16'hC8, 16'h32, 1'h0, 1'h1}, '{8'h00, 16'h64, 16'hC8, 16'h32, 1'h0, 1'h0},
    '{8'h11, 16'h64, 16'h64, 16'h32, 1'h1, 1'h1}, '{8'h21, 16'h64, 16'h64, 16'h32, 1'h1, 1'h1},
    '{8'h01, 16'h64, 16'h64, 16'h32, 1'h1, 1'h0}, '{8'h01, 16'h64, 16'h64, 16'h6F, 1'h0, 1'h1},
    '{8'h05, 16'h64, 16'h64, 16'h6F, 1'h0, 1'h0}};
  // Period 10 ticks of 4 cycles, range 0..100: one tick of high time is 8 cycles in 80
  dutyRow dr[10] = '{'{32'h0, 32'h0, 16'h1E, 1'h0, 8'h18}, '{32'h2, 32'h0, 16'h1E, 1'h0, 8'h38},
    '{32'h3, 32'h0, 16'h1E, 1'h0, 8'h28}, '{32'h140001, 32'h0, 16'h1E, 1'h0, 8'h10},
    '{32'h0, 32'h0, 16'hFFFB, 1'h0, 8'h0}, '{32'h0, 32'h0, 16'h78, 1'h0, 8'h50},
    '{32'h0, 32'h2, 16'hA, 1'h0, 8'h10}, '{32'h0, 32'h30000, 16'h5A, 1'h0, 8'h38},
    '{32'h0, 32'h50006, 16'h1E, 1'h0, 8'h0}, '{32'h3200, 32'h0, 16'h1E, 1'h1, 8'h28}};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic alarm = 1'b0;
  logic clear = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic signed [15:0] measValue = 16'h0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic hreadyout;
  logic hresp;
  logic relayOut;
  logic ocOut;
  int highCnt;
  int lastPeriod;
  int fail_count = 0;
  int checked = 0;
  always #4 mclk = ~mclk;
  threshold_relay_and_duty_output #(.TICK_FAST_CYC(4), .TICK_SLOW_CYC(10)) i_dut (.mclk(mclk),
    .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .measValue(measValue), .loopHValue(16'h46), .loopCValue(16'h32),
    .alarm(alarm), .relayOut(relayOut), .ocOut(ocOut));
  oc_load_model i_load (.mclk(mclk), .clear(clear), .ocOut(ocOut), .highCnt(highCnt),
    .lastPeriod(lastPeriod));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic relayIs(input logic e);
    check("relayOut", {31'h0, relayOut}, {31'h0, e});
  endtask
  task automatic hold(input logic [15:0] m, input int n);
    measValue <= m;
    repeat (n) @(posedge mclk);
  endtask
  // Bounded wait for hready; a stuck bus ends the run instead of hanging it
  task automatic edgeReady;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    edgeReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edgeReady();
    q = hrdata;
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b1, `ADDR_BAND, 32'hA);
    foreach (rr[i])
    begin
      bus(1'b1, `ADDR_MODE, {24'h0, rr[i].c});
      bus(1'b1, `ADDR_THR1, {16'h0, rr[i].a});
      bus(1'b1, `ADDR_THR2, {16'h0, rr[i].b});
      alarm <= rr[i].al;
      hold(rr[i].m, 4);
      relayIs(rr[i].ex);
    end
    $display("relay table done");
    measValue <= 16'h32;
    bus(1'b1, `ADDR_MODE, 32'h1);
    bus(1'b1, `ADDR_DELAY, 32'h30003);
    hold(16'h32, 30);
    hold(16'h6F, 6);
    hold(16'h32, 30);
    relayIs(1'b0);
    hold(16'h6F, 30);
    relayIs(1'b1);
    hold(16'h32, 5);
    relayIs(1'b1);
    hold(16'h32, 30);
    relayIs(1'b0);
    $display("delay test done");
    bus(1'b1, `ADDR_MODE, {29'h0, `MODE_DUTY});
    foreach (dr[i])
    begin
      bus(1'b1, `ADDR_SOURCE, dr[i].s);
      bus(1'b1, `ADDR_MINTIME, dr[i].n);
      alarm <= dr[i].al;
      hold(dr[i].m, 90);
      clear <= 1'b1;
      @(posedge mclk);
      clear <= 1'b0;
      repeat (81) @(posedge mclk);
      check("high cycles", highCnt, {24'h0, dr[i].h});
    end
    check("period", lastPeriod, 32'h28);
    ce <= 1'b0;
    @(posedge mclk);
    q[0] = ocOut;
    repeat (50) @(posedge mclk);
    check("frozen ocOut", {31'h0, ocOut}, {31'h0, q[0]});
    ce <= 1'b1;
    // Slow time unit: ten-cycle tick, so one period is 100 cycles
    bus(1'b1, `ADDR_MODE, 32'h105);
    hold(16'h1E, 250);
    check("slow period", lastPeriod, 32'h64);
    $display("duty tests done");
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, `ADDR_PERIOD, 32'h0);
    check("period reset", q, 32'hA);
    bus(1'b0, `ADDR_RANGE_HI, 32'h0);
    check("range reset", q, 32'h64);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    check("status", q, 32'h4);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", q, 32'h0);
    $display("reset test done");
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
